// *** blf_pkg.sv ***
// Package: register map, field layout and reset values of the balance fault flags
package blf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          CHANNELS   = 14;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          REG_W      = 16;

  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPEN_IDX   = 8'h1a;
  localparam logic [7:0]  SHORT_IDX  = 8'h1b;
  localparam logic [7:0]  STAT_IDX   = 8'h20;
  localparam logic [7:0]  MASK_IDX   = 8'h21;
  localparam logic [7:0]  SUMM_IDX   = 8'h22;
  localparam logic [7:0]  OPEN_ADDR  = 8'h68;
  localparam logic [7:0]  SHORT_ADDR = 8'h6c;
  localparam logic [7:0]  STAT_ADDR  = 8'h80;
  localparam logic [7:0]  MASK_ADDR  = 8'h84;
  localparam logic [7:0]  SUMM_ADDR  = 8'h88;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          SUM_OPEN_BIT  = 0;
  localparam int          SUM_SHORT_BIT = 1;
  localparam logic [13:0] FLAGS_RST  = 14'h0000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;
  localparam logic [31:0] RD_RST     = 32'h0000_0000;

  typedef struct packed {
    logic [13:0] open_flags;
    logic [13:0] short_flags;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [1:0]  sum_prev;
    logic [31:0] rd_data;
  } blf_state_t;

endpackage : blf_pkg

// *** blf_fault_flags.sv ***
// Module: open-load and shorted-load fault flag registers for 14 balance channels
`timescale 1ns/1ps
// How it works
// - Open-load register holds channel 1..14 flags in bits 0..13, bits 14..15 read zero, reset zero.
// - An open-load flag reads one after an off-state open load was detected on its channel.
// - Shorted-load register has the same layout, bits 14..15 zero, reset zero.
// - A shorted-load flag reads one after a shorted load was detected on its channel.
// - Writing zero to a flag bit clears it unless its channel detects in the same cycle; otherwise only reset clears it.
// - Summary outputs are the OR of all open-load flags and of all shorted-load flags.
module blf_fault_flags (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [13:0] open_load_detect,
  input  wire logic [13:0] short_load_detect,
  output logic             summary_open_load,
  output logic             summary_short_load,
  output logic             irq
);

  blf_pkg::blf_state_t state_reg;
  blf_pkg::blf_state_t state_next;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_open;
  logic wr_short;
  logic wr_stat;
  logic wr_mask;
  logic [1:0] sum_now;

  assign wr_open  = reg_wr && (reg_addr == blf_pkg::OPEN_ADDR);
  assign wr_short = reg_wr && (reg_addr == blf_pkg::SHORT_ADDR);
  assign wr_stat  = reg_wr && (reg_addr == blf_pkg::STAT_ADDR);
  assign wr_mask  = reg_wr && (reg_addr == blf_pkg::MASK_ADDR);

  // Summaries come straight off the flag flops
  assign sum_now[blf_pkg::SUM_OPEN_BIT]  = |state_reg.open_flags;
  assign sum_now[blf_pkg::SUM_SHORT_BIT] = |state_reg.short_flags;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Per-channel sticky flags; detection ORed last so it wins over a zero write
    for (int i = 0; i < blf_pkg::CHANNELS; i++) begin
      if (wr_open && !reg_wdata[i]) begin
        state_next.open_flags[i] = 1'b0;
      end
      if (wr_short && !reg_wdata[i]) begin
        state_next.short_flags[i] = 1'b0;
      end
      if (open_load_detect[i]) begin
        state_next.open_flags[i] = 1'b1;
      end
      if (short_load_detect[i]) begin
        state_next.short_flags[i] = 1'b1;
      end
    end
    // Interrupt events: rising edge of either summary; write one to clear, set wins
    state_next.sum_prev = sum_now;
    if (wr_stat) begin
      state_next.irq_status = state_reg.irq_status & ~reg_wdata[1:0];
    end
    state_next.irq_status = state_next.irq_status | (sum_now & ~state_reg.sum_prev);
    if (wr_mask) begin
      state_next.irq_mask = reg_wdata[1:0];
    end
    // Read data lands one cycle after the strobe; unmapped reads give zero
    state_next.rd_data = blf_pkg::RD_RST;
    if (reg_rd) begin
      case (reg_addr)
        blf_pkg::OPEN_ADDR:  state_next.rd_data = {18'h00000, state_reg.open_flags};
        blf_pkg::SHORT_ADDR: state_next.rd_data = {18'h00000, state_reg.short_flags};
        blf_pkg::STAT_ADDR:  state_next.rd_data = {30'h00000000, state_reg.irq_status};
        blf_pkg::MASK_ADDR:  state_next.rd_data = {30'h00000000, state_reg.irq_mask};
        blf_pkg::SUMM_ADDR:  state_next.rd_data = {30'h00000000, sum_now};
        default:             state_next.rd_data = blf_pkg::RD_RST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg.open_flags  <= blf_pkg::FLAGS_RST;
      state_reg.short_flags <= blf_pkg::FLAGS_RST;
      state_reg.irq_status  <= blf_pkg::IRQ_RST;
      state_reg.irq_mask    <= blf_pkg::IRQ_RST;
      state_reg.sum_prev    <= blf_pkg::IRQ_RST;
      state_reg.rd_data     <= blf_pkg::RD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata          = state_reg.rd_data;
  assign summary_open_load  = sum_now[blf_pkg::SUM_OPEN_BIT];
  assign summary_short_load = sum_now[blf_pkg::SUM_SHORT_BIT];
  assign irq                = |(state_reg.irq_status & state_reg.irq_mask);

endmodule : blf_fault_flags

// *** blf_fault_flags_properties.sv ***
// Checker for the fault flag ports
`timescale 1ns/1ps
module blf_checker (
  input wire logic sys_clk, srst, reg_wr, reg_rd, summary_open_load, summary_short_load, irq,
  input wire logic [7:0] reg_addr, input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic [13:0] open_load_detect, short_load_detect);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_op_set: assert property(|open_load_detect |=> summary_open_load) else $error("op");
  a_sh_set: assert property(|short_load_detect |=> summary_short_load) else $error("sh");
  a_flag_hold: assert property($fell(summary_open_load) || $fell(summary_short_load)
    |-> $past(reg_wr)) else $error("fell");
  a_hi_zero: assert property($past(reg_rd) |-> !(|reg_rdata[31:14])) else $error("hi");
  a_op_clr: assert property(reg_wr && reg_addr == 8'h68 && reg_wdata[13:0] == 14'h0
    && open_load_detect == 14'h0 |=> !summary_open_load) else $error("clr");
  a_sh_clr: assert property(reg_wr && reg_addr == 8'h6c && reg_wdata[13:0] == 14'h0
    && short_load_detect == 14'h0 |=> !summary_short_load) else $error("sh clr");
  a_rd_idle: assert property(!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("idle");
  a_irq_fall: assert property($fell(irq) |-> $past(reg_wr)) else $error("irq");
  cover property (reg_rd && reg_addr == 8'h6c);
  cover property (reg_wr && |open_load_detect);
  cover property ($rose(irq));
endmodule : blf_checker
bind blf_fault_flags blf_checker blf_checker_inst (.*);

// *** balance_load_fault_flags_tb.sv ***
// Bench for the fault flag registers
`timescale 1ns/1ps
module balance_load_fault_flags_tb;
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, irq, so, ss;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [13:0] od = 14'h0, sd = 14'h0;
  int fails = 0, n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  blf_fault_flags blf_fault_flags_inst (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .open_load_detect(od), .short_load_detect(sd), .summary_open_load(so),
    .summary_short_load(ss), .irq);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) $display("unexpected %s expected %h seen %h", n, e, g);
    if (g !== e) fails++;
  endtask : chk
  // Gap cycle after each strobe avoids a double assign
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic i);
    {reg_addr, reg_wdata} <= {a, d};
    {reg_wr, reg_rd} <= {w, !w};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1 chk("irq", {31'h0, i}, {31'h0, irq});
    if (!w) chk("rdata", d, reg_rdata);
    @(posedge sys_clk);
  endtask : bus
  task automatic wrap_up();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    #2000 fails++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 0;
    {od, sd} <= {14'h2001, 14'h3fff};
    bus(0, 8'h6c, 32'h0, 0);
    {od, sd} <= 28'h4000;
    bus(0, 8'h6c, 32'h3fff, 0);
    bus(1, 8'h68, 32'h2000, 0);
    bus(1, 8'h84, 32'h3, 1);
    bus(0, 8'h80, 32'h3, 1);
    bus(0, 8'h84, 32'h3, 1);
    bus(1, 8'h80, 32'h3, 0);
    bus(0, 8'h88, 32'h3, 0);
    bus(0, 8'h68, 32'h2001, 0);
    od <= 14'h0;
    bus(1, 8'h68, 32'h0, 0);
    bus(0, 8'h40, 32'h0, 0);
    bus(0, 8'h68, 32'h0, 0);
    #1 chk("summary_open_load", 32'h0, {31'h0, so});
    chk("summary_short_load", 32'h1, {31'h0, ss});
    @(posedge sys_clk);
    bus(1, 8'h6c, 32'h0, 0);
    bus(0, 8'h6c, 32'h0, 0);
    #1 chk("summary_short_load", 32'h0, {31'h0, ss});
    @(posedge sys_clk);
    wrap_up();
  end
endmodule : balance_load_fault_flags_tb
